/* tscs_top.sv */
// Two-speed clock start-up controller with APB registers and interrupt.
// Assumes oscillator pins toggle well below half of pclk; core requests on pclk.
`timescale 1ns/10ps
`default_nettype none
module tscs_top #(
	parameter int STARTUP_CYCLES = tscs_pkg::STARTUP_CYCLES,
	parameter int HOLD_EDGES = tscs_pkg::HOLD_EDGES
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Oscillator pins
	input wire logic internal_rc_clock,
	input wire logic primary_osc_clock,
	input wire logic internal_fast_oscillator,
	input wire logic internal_fast_ready,
	// Core requests
	input wire logic power_up_timer_expired,
	input wire logic sleep_req,
	input wire logic wake_req,
	// Clock outputs and interrupt
	output logic sys_clk,
	output logic sys_clk_from_primary,
	output logic irq
);
	//------------------------------------------------------------
	// Pin synchronisers
	//------------------------------------------------------------
	logic [3:0] sync1_ff;
	logic [3:0] sync2_ff;
	logic [2:0] prev_ff;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_ff <= 4'h0;
			sync2_ff <= 4'h0;
			prev_ff <= 3'h0;
		end else begin
			sync1_ff <= {internal_fast_ready, internal_fast_oscillator, primary_osc_clock, internal_rc_clock};
			sync2_ff <= sync1_ff;
			prev_ff <= sync2_ff[2:0];
		end
	end
	wire logic [2:0] rise = sync2_ff[2:0] & ~prev_ff;
	wire logic [2:0] fall = ~sync2_ff[2:0] & prev_ff;
	wire logic prim_rise = rise[1];
	wire logic prim_fall = fall[1];

	//------------------------------------------------------------
	// Registers and decode
	//------------------------------------------------------------
	tscs_pkg::tscs_state_t state_ff;
	tscs_pkg::tscs_state_t nxt_state;
	tscs_pkg::tscs_cfg_t cfg_ff;
	logic [1:0] system_clock_select_ff;
	logic [2:0] internal_freq_select_ff;
	logic startup_timer_status_flag_ff;
	logic internal_osc_stable_flag_ff;
	logic [2:0] stat_ff;
	logic [2:0] mask_ff;
	logic [10:0] timer_ff;
	logic pready_ff;
	logic [31:0] prdata_ff;
	logic pslverr_ff;
	logic sys_clk_ff;
	logic src_primary_ff;
	logic irq_ff;
	logic first_ff;

	wire logic access = psel & penable;
	wire logic done = access & pready_ff;
	wire logic wr = done & pwrite;
	wire logic rd = done & ~pwrite;
	wire logic hit_osc = paddr == tscs_pkg::ADDR_OSC_CTRL;
	wire logic hit_cfg = paddr == tscs_pkg::ADDR_CFG;
	wire logic hit_stat = paddr == tscs_pkg::ADDR_IRQ_STAT;
	wire logic hit_mask = paddr == tscs_pkg::ADDR_IRQ_MASK;
	wire logic hit = hit_osc | hit_cfg | hit_stat | hit_mask;
	wire logic wr_osc = wr & hit_osc;
	// Configuration is frozen while a start-up sequence is in flight, and in
	// the cycle one starts, so the mode cannot change under it
	wire logic cfg_open = (state_ff == tscs_pkg::ST_IDLE || state_ff == tscs_pkg::ST_PRIMARY
		|| state_ff == tscs_pkg::ST_SLEEP) && nxt_state != tscs_pkg::ST_RC && nxt_state != tscs_pkg::ST_HOLD;
	wire logic wr_cfg = wr & hit_cfg & cfg_open;
	wire logic wr_mask = wr & hit_mask;
	wire logic rd_stat = rd & hit_stat;
	wire tscs_pkg::tscs_osc_ctrl_t osc_view = '{internal_freq_select_ff,
		startup_timer_status_flag_ff, internal_osc_stable_flag_ff, system_clock_select_ff};
	wire logic [31:0] rd_mux = hit_osc ? {25'h0, osc_view} :
		hit_cfg ? {27'h0, cfg_ff} :
		hit_stat ? {29'h0, stat_ff} :
		hit_mask ? {29'h0, mask_ff} : 32'h0;

	//------------------------------------------------------------
	// Start-up conditions
	//------------------------------------------------------------
	// Only crystal-type modes need settling time
	wire logic crystal_mode = cfg_ff.mode == tscs_pkg::MODE_LOW_POWER
		|| cfg_ff.mode == tscs_pkg::MODE_CRYSTAL || cfg_ff.mode == tscs_pkg::MODE_HIGH_SPEED;
	wire logic two_speed = cfg_ff.two_speed_switchover_enable & crystal_mode;
	wire logic start_ok = cfg_ff.power_up_timer_enable_n | power_up_timer_expired;
	wire logic fast_sel = internal_freq_select_ff != 3'h0;
	wire logic int_level = fast_sel ? sync2_ff[2] : sync2_ff[0];
	wire logic int_fall = fast_sel ? fall[2] : fall[0];
	wire logic in_startup = state_ff == tscs_pkg::ST_RC || state_ff == tscs_pkg::ST_WAIT_FALL
		|| state_ff == tscs_pkg::ST_HOLD;
	wire logic timer_end = timer_ff == 11'(STARTUP_CYCLES - 1);
	wire logic hold_end = timer_ff == 11'(HOLD_EDGES - 1);
	wire tscs_pkg::tscs_state_t resume = two_speed ? tscs_pkg::ST_RC : tscs_pkg::ST_HOLD;

	//------------------------------------------------------------
	// Sequencer
	//------------------------------------------------------------
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			tscs_pkg::ST_IDLE: begin
				if (start_ok) begin
					nxt_state = resume;
				end
			end
			tscs_pkg::ST_RC: begin
				if (sleep_req) begin
					nxt_state = tscs_pkg::ST_SLEEP;
				end else if (prim_rise && timer_end) begin
					nxt_state = tscs_pkg::ST_WAIT_FALL;
				end
			end
			tscs_pkg::ST_WAIT_FALL: begin
				if (sleep_req) begin
					nxt_state = tscs_pkg::ST_SLEEP;
				end else if (int_fall && system_clock_select_ff == 2'h0) begin
					nxt_state = tscs_pkg::ST_HOLD;
				end
			end
			tscs_pkg::ST_HOLD: begin
				if (sleep_req) begin
					nxt_state = tscs_pkg::ST_SLEEP;
				end else if (prim_fall && hold_end) begin
					nxt_state = tscs_pkg::ST_PRIMARY;
				end
			end
			tscs_pkg::ST_PRIMARY: begin
				if (sleep_req) begin
					nxt_state = tscs_pkg::ST_SLEEP;
				end
			end
			tscs_pkg::ST_SLEEP: begin
				if (wake_req) begin
					nxt_state = resume;
				end
			end
			default: begin
				nxt_state = tscs_pkg::ST_IDLE;
			end
		endcase
	end

	// One counter serves both the start-up count and the low hold
	wire logic cnt_step = (state_ff == tscs_pkg::ST_RC && prim_rise)
		|| (state_ff == tscs_pkg::ST_HOLD && prim_fall);
	wire logic [10:0] nxt_timer = (nxt_state != state_ff) ? 11'h0 :
		cnt_step ? 11'(timer_ff + 11'h1) : timer_ff;
	// Internal clock until handover, held low during the hold, then primary
	wire logic nxt_sys_clk = (state_ff == tscs_pkg::ST_RC || state_ff == tscs_pkg::ST_WAIT_FALL) ?
		int_level : (state_ff == tscs_pkg::ST_PRIMARY) ? sync2_ff[1] : 1'b0;
	wire logic nxt_primary = nxt_state == tscs_pkg::ST_PRIMARY;
	wire logic nxt_stable = fast_sel & sync2_ff[3];
	// Abort is flagged only when sleep cuts a start-up short
	wire logic [2:0] events = {sleep_req & in_startup,
		nxt_stable & ~internal_osc_stable_flag_ff,
		nxt_primary & ~startup_timer_status_flag_ff};
	// Set wins over the read clear
	wire logic [2:0] nxt_stat = events | (stat_ff & {3{~rd_stat}});

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= tscs_pkg::ST_IDLE;
			timer_ff <= 11'h0;
			sys_clk_ff <= 1'b0;
			src_primary_ff <= 1'b0;
			startup_timer_status_flag_ff <= 1'b0;
			internal_osc_stable_flag_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			timer_ff <= nxt_timer;
			sys_clk_ff <= nxt_sys_clk;
			src_primary_ff <= nxt_primary;
			startup_timer_status_flag_ff <= nxt_primary;
			internal_osc_stable_flag_ff <= nxt_stable;
		end
	end

	//------------------------------------------------------------
	// Software registers
	//------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			system_clock_select_ff <= tscs_pkg::SEL_RESET;
			internal_freq_select_ff <= tscs_pkg::FREQ_RESET;
			cfg_ff <= tscs_pkg::CFG_RESET;
			mask_ff <= tscs_pkg::MASK_RESET;
		end else begin
			if (wr_osc) begin
				system_clock_select_ff <= pwdata[1:0];
				internal_freq_select_ff <= pwdata[6:4];
			end
			if (wr_cfg) begin
				cfg_ff <= pwdata[4:0];
			end
			if (wr_mask) begin
				mask_ff <= pwdata[2:0];
			end
		end
	end

	//------------------------------------------------------------
	// APB answer and interrupt
	//------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff <= 1'b0;
			prdata_ff <= 32'h0;
			pslverr_ff <= 1'b0;
			stat_ff <= 3'h0;
			irq_ff <= 1'b0;
			first_ff <= 1'b0;
		end else begin
			pready_ff <= access & ~pready_ff;
			if (access && !pready_ff) begin
				prdata_ff <= pwrite ? 32'h0 : rd_mux;
				pslverr_ff <= ~hit;
			end
			stat_ff <= nxt_stat;
			irq_ff <= |(stat_ff & mask_ff);
			first_ff <= 1'b1;
		end
	end

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign sys_clk = sys_clk_ff;
	assign sys_clk_from_primary = src_primary_ff;
	assign irq = irq_ff;

	//------------------------------------------------------------
	// Assertions
	//------------------------------------------------------------
	property p_rc_run;
		@(posedge pclk) disable iff (!presetn)
		(state_ff == tscs_pkg::ST_RC) |-> !src_primary_ff && !startup_timer_status_flag_ff;
	endproperty
	a_rc_run: assert property (p_rc_run) else $error("primary used during start-up");

	property p_wake;
		@(posedge pclk) disable iff (!presetn)
		(state_ff == tscs_pkg::ST_SLEEP && wake_req && two_speed) |=> state_ff == tscs_pkg::ST_RC;
	endproperty
	a_wake: assert property (p_wake) else $error("wake did not start two-speed");

	property p_sel_reset;
		@(posedge pclk) disable iff (!presetn)
		!first_ff |-> system_clock_select_ff == 2'h0;
	endproperty
	a_sel_reset: assert property (p_sel_reset) else $error("clock select not cleared by reset");

	property p_freq_reset;
		@(posedge pclk) disable iff (!presetn)
		!first_ff |-> internal_freq_select_ff == 3'h0;
	endproperty
	a_freq_reset: assert property (p_freq_reset) else $error("freq select not cleared by reset");

	property p_mode;
		@(posedge pclk) disable iff (!presetn)
		(state_ff == tscs_pkg::ST_RC) |-> crystal_mode && cfg_ff.two_speed_switchover_enable;
	endproperty
	a_mode: assert property (p_mode) else $error("two-speed run in wrong mode");

	property p_fast_flag;
		@(posedge pclk) disable iff (!presetn)
		internal_osc_stable_flag_ff |-> $past(fast_sel) && $past(sync2_ff[3]);
	endproperty
	a_fast_flag: assert property (p_fast_flag) else $error("stable flag without stable oscillator");

	// Flag must track the sequencer state, not only the source register
	property p_status;
		@(posedge pclk) disable iff (!presetn)
		startup_timer_status_flag_ff == (state_ff == tscs_pkg::ST_PRIMARY)
			&& startup_timer_status_flag_ff == src_primary_ff;
	endproperty
	a_status: assert property (p_status) else $error("status flag disagrees with source");

	property p_sel_write;
		@(posedge pclk) disable iff (!presetn)
		(wr_osc && state_ff == tscs_pkg::ST_RC) |=> system_clock_select_ff == $past(pwdata[1:0]);
	endproperty
	a_sel_write: assert property (p_sel_write) else $error("clock select write lost");

	property p_abort;
		@(posedge pclk) disable iff (!presetn)
		(sleep_req && in_startup) |=> state_ff == tscs_pkg::ST_SLEEP && timer_ff == 11'h0
			&& !startup_timer_status_flag_ff;
	endproperty
	a_abort: assert property (p_abort) else $error("sleep did not abort start-up");

	property p_count;
		@(posedge pclk) disable iff (!presetn)
		(state_ff == tscs_pkg::ST_RC && nxt_state == tscs_pkg::ST_WAIT_FALL)
			|-> timer_ff == 11'(STARTUP_CYCLES - 1) && prim_rise;
	endproperty
	a_count: assert property (p_count) else $error("start-up count wrong");

	property p_fall_wait;
		@(posedge pclk) disable iff (!presetn)
		(state_ff == tscs_pkg::ST_WAIT_FALL && int_fall && !sleep_req && system_clock_select_ff == 2'h0)
			|=> state_ff == tscs_pkg::ST_HOLD;
	endproperty
	a_fall_wait: assert property (p_fall_wait) else $error("no move on internal falling edge");

	property p_hold;
		@(posedge pclk) disable iff (!presetn)
		(state_ff == tscs_pkg::ST_HOLD) |=> !sys_clk_ff;
	endproperty
	a_hold: assert property (p_hold) else $error("system clock not held low");

	// Source changes only after the low hold
	property p_handover;
		@(posedge pclk) disable iff (!presetn)
		$rose(src_primary_ff) |-> !sys_clk_ff && !$past(sys_clk_ff);
	endproperty
	a_handover: assert property (p_handover) else $error("handover with clock high");
endmodule : tscs_top
`default_nettype wire

/* tscs_pkg.sv */
// Constants, types and register layout for the two-speed clock start-up block.
// Assumes an APB master on pclk and oscillator clocks arriving as plain pins.
//------------------------------------------------------------
// How it works
//------------------------------------------------------------
// How it works
// - With two-speed enabled, code runs on internal RC (fast oscillator if internal select is nonzero) until primary is stable.
// - Start after power-up timer (if enabled), after wake, or after any reset.
// - Reset forces the system clock select field to 00.
// - Reset clears internal frequency select, giving the slowest internal rate.
// - Two-speed start-up only for low-power, crystal or high-speed crystal modes.
// - Nonzero internal select uses fast oscillator; stable flag clear until it settles.
// - Start-up status flag set only while primary clock drives the system clock.
// - Software may write clock select during start-up, before the timer ends.
// - Sleep during start-up aborts the count and leaves the status flag clear.
// - Start-up timer counts 1024 primary oscillator cycles.
// - After timer expiry wait for a falling internal clock edge, then switch.
// - Hold system clock low for eight primary falling edges, then route primary.
package tscs_pkg;
	//------------------------------------------------------------
	// Register offsets
	//------------------------------------------------------------
	localparam logic [11:0] ADDR_OSC_CTRL = 12'h000;
	localparam logic [11:0] ADDR_CFG = 12'h004;
	localparam logic [11:0] ADDR_IRQ_STAT = 12'h008;
	localparam logic [11:0] ADDR_IRQ_MASK = 12'h00c;
	//------------------------------------------------------------
	// Primary oscillator modes
	//------------------------------------------------------------
	localparam logic [2:0] MODE_LOW_POWER = 3'h0;
	localparam logic [2:0] MODE_CRYSTAL = 3'h1;
	localparam logic [2:0] MODE_HIGH_SPEED = 3'h2;
	//------------------------------------------------------------
	// Timing counts in primary oscillator edges
	//------------------------------------------------------------
	localparam int STARTUP_CYCLES = 1024;
	localparam int HOLD_EDGES = 8;
	//------------------------------------------------------------
	// Register layouts and reset values
	//------------------------------------------------------------
	typedef struct packed {
		logic [2:0] internal_freq_select;
		logic startup_timer_status_flag;
		logic internal_osc_stable_flag;
		logic [1:0] system_clock_select;
	} tscs_osc_ctrl_t;
	typedef struct packed {
		logic two_speed_switchover_enable;
		logic power_up_timer_enable_n;
		logic [2:0] mode;
	} tscs_cfg_t;
	localparam logic [1:0] SEL_RESET = 2'h0;
	localparam logic [2:0] FREQ_RESET = 3'h0;
	localparam tscs_cfg_t CFG_RESET = '{1'b1, 1'b1, 3'h1};
	localparam logic [2:0] MASK_RESET = 3'h0;
	// Interrupt status bits
	localparam int EV_SWITCHED = 0;
	localparam int EV_FAST_STABLE = 1;
	localparam int EV_ABORT = 2;
	//------------------------------------------------------------
	// Sequencer states
	//------------------------------------------------------------
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_RC = 6'h02,
		ST_WAIT_FALL = 6'h04,
		ST_HOLD = 6'h08,
		ST_PRIMARY = 6'h10,
		ST_SLEEP = 6'h20
	} tscs_state_t;
endpackage : tscs_pkg

/* tscs_osc_model.sv */
// Behavioural oscillators on the far side of the two-speed start-up block.
// Assumes the bench raises fast_go when the fast internal oscillator is powered.
`timescale 1ns/10ps
`default_nettype none
module tscs_osc_model (
	// Control
	input wire logic fast_go,
	// Oscillator pins
	output logic internal_rc_clock,
	output logic primary_osc_clock,
	output logic internal_fast_oscillator,
	output logic internal_fast_ready
);
	//------------------------------------------------------------
	// Free-running sources, phases unrelated to pclk
	//------------------------------------------------------------
	initial begin
		internal_rc_clock = 1'b0;
		primary_osc_clock = 1'b0;
		internal_fast_oscillator = 1'b0;
		internal_fast_ready = 1'b0;
	end
	always #203 internal_rc_clock = ~internal_rc_clock;
	always #101 primary_osc_clock = ~primary_osc_clock;
	always #83 internal_fast_oscillator = ~internal_fast_oscillator;
	// Settling time before the fast oscillator reports stable
	always @(fast_go) internal_fast_ready <= #500 fast_go;
endmodule : tscs_osc_model
`default_nettype wire

/* tb_top.sv */
// Self-checking bench for the two-speed clock start-up block over APB.
// Assumes the behavioural oscillator model and shortened start-up counts.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	localparam int SU = 16;
	localparam int HE = 2;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, mon_on, sprev, swprev;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic internal_rc_clock, primary_osc_clock, internal_fast_oscillator, internal_fast_ready;
	logic power_up_timer_expired, sleep_req, wake_req, sys_clk, sys_clk_from_primary, irq, fast_go;
	int fail_count, cmp_count, run, low_at_sw, n;
	tscs_pkg::tscs_osc_ctrl_t oc;
	tscs_top #(.STARTUP_CYCLES(SU), .HOLD_EDGES(HE)) i_tscs_top (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .internal_rc_clock, .primary_osc_clock,
		.internal_fast_oscillator, .internal_fast_ready, .power_up_timer_expired, .sleep_req,
		.wake_req, .sys_clk, .sys_clk_from_primary, .irq);
	tscs_osc_model i_tscs_osc_model (.fast_go, .internal_rc_clock, .primary_osc_clock,
		.internal_fast_oscillator, .internal_fast_ready);
	always #10 pclk = ~pclk;
	//------------------------------------------------------------
	// Tasks
	//------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic report_and_stop();
		if (fail_count == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : report_and_stop
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 20) check(32'(k), 32'h0);
	endtask : apb
	task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(rd, exp);
	endtask : rdchk
	task automatic pulse(input bit s);
		@(posedge pclk);
		if (s) sleep_req <= 1'b1;
		else wake_req <= 1'b1;
		@(posedge pclk);
		sleep_req <= 1'b0;
		wake_req <= 1'b0;
		repeat (4) @(posedge pclk);
	endtask : pulse
	task automatic wait_sw();
		n = 0;
		while (sys_clk_from_primary !== 1'b1 && n < 3000) begin
			@(posedge pclk);
			n++;
		end
		@(posedge pclk);
	endtask : wait_sw
	task automatic do_reset();
		presetn <= 1'b0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
	endtask : do_reset
	//------------------------------------------------------------
	// System clock pulse-width monitor
	//------------------------------------------------------------
	always @(posedge pclk) begin
		sprev <= sys_clk;
		swprev <= sys_clk_from_primary;
		if (sys_clk_from_primary === 1'b1 && swprev === 1'b0) low_at_sw <= run;
		if (sys_clk !== sprev) begin
			if (mon_on) check(32'(run >= 3), 32'h1);
			run <= 1;
		end else begin
			run <= run + 1;
		end
	end
	//------------------------------------------------------------
	// Main sequence
	//------------------------------------------------------------
	initial begin
		{pclk, psel, penable, pwrite, sleep_req, wake_req, fast_go, mon_on, err} = '0;
		{paddr, pwdata, rd} = '0;
		{fail_count, cmp_count, run, low_at_sw, n} = '0;
		presetn = 1'b0;
		power_up_timer_expired = 1'b1;
		do_reset();
		mon_on = 1'b1;
		wait_sw();
		check(32'(n >= 150 && n <= 230), 32'h1);
		check(32'(low_at_sw >= 10), 32'h1);
		mon_on = 1'b0;
		oc = '0;
		oc.startup_timer_status_flag = 1'b1;
		rdchk(tscs_pkg::ADDR_OSC_CTRL, 32'(oc));
		rdchk(tscs_pkg::ADDR_CFG, 32'h19);
		rdchk(12'h010, 32'h0);
		check(32'(err), 32'h1);
		check(32'(irq), 32'h0);
		apb(1'b1, tscs_pkg::ADDR_IRQ_MASK, 32'h7);
		repeat (3) @(posedge pclk);
		check(32'(irq), 32'h1);
		rdchk(tscs_pkg::ADDR_IRQ_STAT, 32'h1);
		repeat (3) @(posedge pclk);
		check(32'(irq), 32'h0);
		// Sleep from primary, wake, then sleep again inside start-up
		pulse(1'b1);
		check({30'h0, sys_clk, sys_clk_from_primary}, 32'h0);
		pulse(1'b0);
		repeat (40) @(posedge pclk);
		pulse(1'b1);
		repeat (300) @(posedge pclk);
		oc = '0;
		rdchk(tscs_pkg::ADDR_OSC_CTRL, 32'(oc));
		rdchk(tscs_pkg::ADDR_IRQ_STAT, 32'h4);
		// Clock select written during start-up stalls the switch
		pulse(1'b0);
		apb(1'b1, tscs_pkg::ADDR_OSC_CTRL, 32'h1);
		repeat (300) @(posedge pclk);
		oc.system_clock_select = 2'h1;
		rdchk(tscs_pkg::ADDR_OSC_CTRL, 32'(oc));
		check(32'(sys_clk_from_primary), 32'h0);
		apb(1'b1, tscs_pkg::ADDR_OSC_CTRL, 32'h0);
		wait_sw();
		check(32'(n < 60), 32'h1);
		// Fast internal oscillator stable flag
		apb(1'b1, tscs_pkg::ADDR_OSC_CTRL, 32'h10);
		oc = '0;
		oc.internal_freq_select = 3'h1;
		oc.startup_timer_status_flag = 1'b1;
		rdchk(tscs_pkg::ADDR_OSC_CTRL, 32'(oc));
		fast_go <= 1'b1;
		repeat (60) @(posedge pclk);
		oc.internal_osc_stable_flag = 1'b1;
		rdchk(tscs_pkg::ADDR_OSC_CTRL, 32'(oc));
		rdchk(tscs_pkg::ADDR_IRQ_STAT, 32'h3);
		// Two-speed restart with the fast internal oscillator selected
		pulse(1'b1);
		pulse(1'b0);
		wait_sw();
		check(32'(n >= 140 && n <= 230), 32'h1);
		// Non-crystal mode skips the start-up count
		apb(1'b1, tscs_pkg::ADDR_CFG, 32'h1b);
		rdchk(tscs_pkg::ADDR_CFG, 32'h1b);
		pulse(1'b1);
		pulse(1'b0);
		wait_sw();
		check(32'(n < 60), 32'h1);
		// Reset in mid-run restores clock fields
		do_reset();
		oc = '0;
		rdchk(tscs_pkg::ADDR_OSC_CTRL, 32'(oc));
		rdchk(tscs_pkg::ADDR_CFG, 32'h19);
		rdchk(tscs_pkg::ADDR_IRQ_MASK, 32'h0);
		report_and_stop();
	end
	initial begin
		#400000;
		fail_count++;
		report_and_stop();
	end
endmodule : tb_top
`default_nettype wire
